// [rtl/cbes_pkg.sv]
// Function
// RULE1: a fill ECC or parity error locks the data-cache status register.
// RULE2: reading the unlock pseudo-register releases the data-cache status lock.
// RULE3: hit flag follows whether the last load or store hit the data cache.
// RULE4: a locking error while already locked sets the data-cache second-error flag.
// RULE5: lock captures register field, integer, longword and legacy float flags; the code stores the legacy float flag only for non-integer fills.
// RULE6: lock captures a locked-access flag and a store flag.
// RULE7: modifier fields mean something only while a fill error flag is set.
// RULE8: bus or tag errors freeze bus status bits 6..0 and the error address.
// RULE9: fill errors also freeze bus status bits 6..0 and the error address.
// RULE10: reading the bus error address unlocks bus status bits 7..0.
// RULE11: fill errors freeze bus status bits 13..8 and the fill address.
// RULE12: reading the fill address unlocks bus status bits 13..8.
// RULE13: reset neither clears nor unlocks the bus status register.
// RULE14: hard or soft acknowledge terminations set the matching bus error flag.
// RULE15: tag or tag-control parity faults set the matching parity flag.
// RULE16: a bus or tag error latches the request pin cycle type.
// RULE17: hard or tag faults while a bus flag is set set the bus second-error flag.
// RULE18: fill data with an ECC error sets the fill ECC flag.
// RULE19: in parity mode, fill data with a parity error sets the fill parity flag.
// RULE20: fill-source flag is set for instruction fills, clear for data fills.
// RULE21: the bad quadword number within the 32-byte block is recorded.
// RULE22: a fill error while a fill flag is set sets the fill second-error flag.
// RULE23: fill address holds physical address bits 33..5 of the block.
// RULE24: while locked only the second-error flag updates; other values hold. The hit flag still follows every access.
package cbes_pkg;
    localparam int CBES_ACK_W = 3;
    localparam int CBES_CMD_W = 3;
    localparam int CBES_RA_W = 5;
    localparam int CBES_QW_W = 2;
    localparam int CBES_ADR_W = 29;
    localparam logic [2:0] CBES_ACK_HARD = 3'h3;
    localparam logic [2:0] CBES_ACK_SOFT = 3'h2;
    // bus status field positions
    localparam int CBES_B_HERR = 0;
    localparam int CBES_B_SERR = 1;
    localparam int CBES_B_TPERR = 2;
    localparam int CBES_B_TCPERR = 3;
    localparam int CBES_B_CMD = 4;
    localparam int CBES_B_SEO = 7;
    localparam int CBES_B_ECC = 8;
    localparam int CBES_B_DPERR = 9;
    localparam int CBES_B_IRD = 10;
    localparam int CBES_B_QW = 11;
    localparam int CBES_B_FSEO = 13;
    // data-cache status field positions
    localparam int CBES_D_HIT = 0;
    localparam int CBES_D_SEO = 1;
    localparam int CBES_D_RA = 2;
    localparam int CBES_D_INT = 7;
    localparam int CBES_D_LW = 8;
    localparam int CBES_D_LFP = 9;
    localparam int CBES_D_LOCK = 10;
    localparam int CBES_D_STORE = 11;
    localparam int CBES_ADR_LSB = 5;
endpackage

// [rtl/cbes_lock_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cbes_lock_if;
    logic lock_set;
    logic unlock;
    logic second_set;
    logic locked;
    logic dcache_second_error;
    modport owner(input lock_set, input unlock, input second_set,
        output locked, output dcache_second_error);
    modport user(output lock_set, output unlock, output second_set,
        input locked, input dcache_second_error);
endinterface
`default_nettype wire

// [rtl/cbes_lock.sv]
`timescale 1ns/1ps
`default_nettype none
module cbes_lock (
    input wire logic i_clk,
    cbes_lock_if.owner lk
);
    logic locked_q;
    logic seo_q;
    logic locked_d;
    logic seo_d;
    // no reset: lock state survives reset by design
    assign locked_d = lk.lock_set | (locked_q & ~lk.unlock);
    assign seo_d = (locked_q & lk.second_set) | (seo_q & ~lk.unlock);
    always_ff @(posedge i_clk) begin
        locked_q <= locked_d;
        seo_q <= seo_d;
    end
    assign lk.locked = locked_q;
    assign lk.dcache_second_error = seo_q;
endmodule // cbes_lock
`default_nettype wire

// [rtl/cbes_top.sv]
`timescale 1ns/1ps
`default_nettype none
module cbes_top (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_access_valid,
    input wire logic i_access_hit,
    input wire logic i_fill_valid,
    input wire logic i_fill_ecc_err,
    input wire logic i_fill_par_err,
    input wire logic i_parity_mode,
    input wire logic i_fill_icache,
    input wire logic [1:0] i_fill_bad_quadword,
    input wire logic [28:0] i_fill_addr,
    input wire logic [4:0] i_fill_ra,
    input wire logic i_fill_int,
    input wire logic i_fill_lw,
    input wire logic i_fill_legacy_fp,
    input wire logic i_fill_locked_op,
    input wire logic i_fill_store,
    input wire logic i_cycle_end,
    input wire logic [2:0] i_cycle_ack_pins,
    input wire logic [2:0] i_cycle_request_pins,
    input wire logic [28:0] i_cycle_addr,
    input wire logic i_tag_probe,
    input wire logic i_tag_par_err,
    input wire logic i_tag_ctl_par_err,
    input wire logic i_rd_dcache_status,
    input wire logic i_rd_dcache_unlock,
    input wire logic i_rd_bus_status,
    input wire logic i_rd_bus_error_address,
    input wire logic i_rd_fill_address,
    output logic [63:0] o_rd_data,
    output logic o_dcache_locked,
    output logic o_bus_locked,
    output logic o_fill_locked
);
    // data-cache status: hit flag plus context captured on a fill error
    logic hit_q;
    logic hit_d;
    logic [cbes_pkg::CBES_RA_W-1:0] ra_q;
    logic [cbes_pkg::CBES_RA_W-1:0] ra_d;
    logic int_q;
    logic int_d;
    logic lw_q;
    logic lw_d;
    logic lfp_q;
    logic lfp_d;
    logic lkop_q;
    logic lkop_d;
    logic store_q;
    logic store_d;

    // low half of the bus status register and the bus error address
    logic herr_q;
    logic herr_d;
    logic serr_q;
    logic serr_d;
    logic tperr_q;
    logic tperr_d;
    logic tcperr_q;
    logic tcperr_d;
    logic [cbes_pkg::CBES_CMD_W-1:0] cmd_q;
    logic [cbes_pkg::CBES_CMD_W-1:0] cmd_d;
    logic [cbes_pkg::CBES_ADR_W-1:0] bus_addr_q;
    logic [cbes_pkg::CBES_ADR_W-1:0] bus_addr_d;

    // high half of the bus status register and the fill address
    logic ecc_q;
    logic ecc_d;
    logic dperr_q;
    logic dperr_d;
    logic ird_q;
    logic ird_d;
    logic [cbes_pkg::CBES_QW_W-1:0] qw_q;
    logic [cbes_pkg::CBES_QW_W-1:0] qw_d;
    logic [cbes_pkg::CBES_ADR_W-1:0] fill_addr_q;
    logic [cbes_pkg::CBES_ADR_W-1:0] fill_addr_d;

    // read path
    logic [63:0] dc_word;
    logic [63:0] bus_word;
    logic [63:0] badr_word;
    logic [63:0] fadr_word;
    logic [63:0] rd_data_d;
    logic [63:0] rd_data_q;
    logic rd_any;

    cbes_lock_if dc_if();
    cbes_lock_if bus_if();
    cbes_lock_if fill_if();

    // event decode; every event is a one-cycle strobe qualified here
    wire ack_hard = i_cycle_end
        & (i_cycle_ack_pins == cbes_pkg::CBES_ACK_HARD); // [RULE14]
    wire ack_soft = i_cycle_end
        & (i_cycle_ack_pins == cbes_pkg::CBES_ACK_SOFT); // [RULE14]
    wire tperr = i_tag_probe & i_tag_par_err; // [RULE15]
    wire tcperr = i_tag_probe & i_tag_ctl_par_err; // [RULE15]
    wire ecc_ev = i_fill_valid & i_fill_ecc_err; // [RULE18]
    // parity is ignored in ecc mode, where the check bits mean otherwise
    wire par_ev = i_fill_valid & i_fill_par_err & i_parity_mode; // [RULE19]
    wire fill_ev = ecc_ev | par_ev;
    wire bus_ev = ack_hard | ack_soft | tperr | tcperr;
    wire any_bus_flag = herr_q | serr_q | tperr_q | tcperr_q;
    // hard and tag faults count as second errors, soft ones do not
    wire bseo_set = (ack_hard | tperr | tcperr) & any_bus_flag; // [RULE17]

    // unlocking reads; an event in the same cycle wins and relocks
    wire dc_unl = i_rd_dcache_unlock; // [RULE2]
    wire bus_unl = i_rd_bus_error_address; // [RULE10]
    wire fill_unl = i_rd_fill_address; // [RULE12]
    wire dc_open = ~dc_if.locked | dc_unl;
    wire bus_open = ~bus_if.locked | bus_unl;
    wire fill_open = ~fill_if.locked | fill_unl;
    wire cap_dc = fill_ev & dc_open; // [RULE1] [RULE7]
    wire cap_bus = bus_ev & bus_open; // [RULE8]
    wire cap_fill = fill_ev & fill_open; // [RULE11]

    // fill errors lock the low bus half too, so its address holds
    assign bus_if.lock_set = (bus_ev | fill_ev) & bus_open; // [RULE8] [RULE9]
    assign bus_if.unlock = bus_unl; // [RULE10]
    assign bus_if.second_set = bseo_set & ~bus_unl; // [RULE17]
    assign fill_if.lock_set = cap_fill; // [RULE11]
    assign fill_if.unlock = fill_unl; // [RULE12]
    assign fill_if.second_set = fill_ev & (ecc_q | dperr_q)
        & ~fill_unl; // [RULE22]
    assign dc_if.lock_set = cap_dc; // [RULE1]
    assign dc_if.unlock = dc_unl; // [RULE2]
    assign dc_if.second_set = fill_ev & ~dc_unl; // [RULE4]

    // lock state has no reset; firmware clears it with the unlocking reads
    cbes_lock u_dc (.i_clk(i_clk), .lk(dc_if)); // [RULE13]
    cbes_lock u_bus (.i_clk(i_clk), .lk(bus_if)); // [RULE13]
    cbes_lock u_fill (.i_clk(i_clk), .lk(fill_if)); // [RULE13]

    // hit flag tracks every access; it is not part of the locked context
    assign hit_d = i_access_valid ? i_access_hit : hit_q; // [RULE3]
    assign ra_d = cap_dc ? i_fill_ra : ra_q; // [RULE5] [RULE24]
    assign int_d = cap_dc ? i_fill_int : int_q; // [RULE5]
    assign lw_d = cap_dc ? i_fill_lw : lw_q; // [RULE5]
    // the legacy float flag has no meaning for integer accesses
    assign lfp_d = cap_dc ? (i_fill_legacy_fp & ~i_fill_int)
        : lfp_q; // [RULE5]
    assign lkop_d = cap_dc ? i_fill_locked_op : lkop_q; // [RULE6]
    assign store_d = cap_dc ? i_fill_store : store_q; // [RULE6]

    // a bus error captures; the unlocking read clears; otherwise hold
    assign herr_d = cap_bus ? ack_hard
        : (bus_unl ? 1'h0 : herr_q); // [RULE14]
    assign serr_d = cap_bus ? ack_soft
        : (bus_unl ? 1'h0 : serr_q); // [RULE14]
    assign tperr_d = cap_bus ? tperr
        : (bus_unl ? 1'h0 : tperr_q); // [RULE15]
    assign tcperr_d = cap_bus ? tcperr
        : (bus_unl ? 1'h0 : tcperr_q); // [RULE15]
    assign cmd_d = cap_bus ? i_cycle_request_pins
        : (bus_unl ? '0 : cmd_q); // [RULE16]
    assign bus_addr_d = cap_bus ? i_cycle_addr
        : (bus_unl ? '0 : bus_addr_q); // [RULE8]

    // ECC and parity fill flags follow the same capture, clear and hold order
    assign ecc_d = cap_fill ? ecc_ev
        : (fill_unl ? 1'h0 : ecc_q); // [RULE18]
    assign dperr_d = cap_fill ? par_ev
        : (fill_unl ? 1'h0 : dperr_q); // [RULE19]
    assign ird_d = cap_fill ? i_fill_icache : ird_q; // [RULE20]
    assign qw_d = cap_fill ? i_fill_bad_quadword : qw_q; // [RULE21]
    assign fill_addr_d = cap_fill ? i_fill_addr : fill_addr_q; // [RULE23]

    // only the hit flag and the read register see reset; status survives
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            hit_q <= 1'h0;
        end else begin
            hit_q <= hit_d;
        end
    end

    always_ff @(posedge i_clk) begin
        ra_q <= ra_d;
    end

    always_ff @(posedge i_clk) begin
        int_q <= int_d;
    end

    always_ff @(posedge i_clk) begin
        lw_q <= lw_d;
    end

    always_ff @(posedge i_clk) begin
        lfp_q <= lfp_d;
    end

    always_ff @(posedge i_clk) begin
        lkop_q <= lkop_d;
    end

    always_ff @(posedge i_clk) begin
        store_q <= store_d;
    end

    always_ff @(posedge i_clk) begin
        herr_q <= herr_d;
    end

    always_ff @(posedge i_clk) begin
        serr_q <= serr_d;
    end

    always_ff @(posedge i_clk) begin
        tperr_q <= tperr_d;
    end

    always_ff @(posedge i_clk) begin
        tcperr_q <= tcperr_d;
    end

    always_ff @(posedge i_clk) begin
        cmd_q <= cmd_d;
    end

    always_ff @(posedge i_clk) begin
        bus_addr_q <= bus_addr_d;
    end

    always_ff @(posedge i_clk) begin
        ecc_q <= ecc_d;
    end

    always_ff @(posedge i_clk) begin
        dperr_q <= dperr_d;
    end

    always_ff @(posedge i_clk) begin
        ird_q <= ird_d;
    end

    always_ff @(posedge i_clk) begin
        qw_q <= qw_d;
    end

    always_ff @(posedge i_clk) begin
        fill_addr_q <= fill_addr_d;
    end

    // read data stands until the next read strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd_data_q <= '0;
        end else if (rd_any) begin
            rd_data_q <= rd_data_d;
        end
    end

    // read words; unused positions read as zero
    always_comb begin
        dc_word = '0;
        dc_word[cbes_pkg::CBES_D_HIT] = hit_q; // [RULE3]
        dc_word[cbes_pkg::CBES_D_SEO] = dc_if.dcache_second_error; // [RULE4]
        dc_word[cbes_pkg::CBES_D_RA +: cbes_pkg::CBES_RA_W] = ra_q; // [RULE5]
        dc_word[cbes_pkg::CBES_D_INT] = int_q; // [RULE5]
        dc_word[cbes_pkg::CBES_D_LW] = lw_q; // [RULE5]
        dc_word[cbes_pkg::CBES_D_LFP] = lfp_q; // [RULE5]
        dc_word[cbes_pkg::CBES_D_LOCK] = lkop_q; // [RULE6]
        dc_word[cbes_pkg::CBES_D_STORE] = store_q; // [RULE6]
    end

    always_comb begin
        bus_word = '0;
        bus_word[cbes_pkg::CBES_B_HERR] = herr_q; // [RULE14]
        bus_word[cbes_pkg::CBES_B_SERR] = serr_q; // [RULE14]
        bus_word[cbes_pkg::CBES_B_TPERR] = tperr_q; // [RULE15]
        bus_word[cbes_pkg::CBES_B_TCPERR] = tcperr_q; // [RULE15]
        bus_word[cbes_pkg::CBES_B_CMD +: cbes_pkg::CBES_CMD_W] = cmd_q;
        bus_word[cbes_pkg::CBES_B_SEO] = bus_if.dcache_second_error; // [RULE17]
        bus_word[cbes_pkg::CBES_B_ECC] = ecc_q; // [RULE18]
        bus_word[cbes_pkg::CBES_B_DPERR] = dperr_q; // [RULE19]
        bus_word[cbes_pkg::CBES_B_IRD] = ird_q; // [RULE20]
        bus_word[cbes_pkg::CBES_B_QW +: cbes_pkg::CBES_QW_W] = qw_q;
        bus_word[cbes_pkg::CBES_B_FSEO] = fill_if.dcache_second_error; // [RULE22]
    end

    always_comb begin
        badr_word = '0;
        badr_word[cbes_pkg::CBES_ADR_LSB +: cbes_pkg::CBES_ADR_W] =
            bus_addr_q; // [RULE8]
    end

    always_comb begin
        fadr_word = '0;
        fadr_word[cbes_pkg::CBES_ADR_LSB +: cbes_pkg::CBES_ADR_W] =
            fill_addr_q; // [RULE23]
    end

    // one strobe at a time is expected; the order below settles overlaps
    assign rd_any = i_rd_dcache_status | i_rd_dcache_unlock | i_rd_bus_status
        | i_rd_bus_error_address | i_rd_fill_address;
    // the unlock pseudo-register holds nothing and reads as zero
    assign rd_data_d = i_rd_dcache_status ? dc_word
        : i_rd_bus_status ? bus_word
        : i_rd_bus_error_address ? badr_word
        : i_rd_fill_address ? fadr_word
        : '0; // [RULE2]

    // outputs come straight from the read register and the lock flops
    assign o_rd_data = rd_data_q;
    assign o_dcache_locked = dc_if.locked;
    assign o_bus_locked = bus_if.locked;
    assign o_fill_locked = fill_if.locked;

    // checks on what the block itself drives
    a_dc_lock_set: assert property (@(posedge i_clk) // [RULE1]
        fill_ev |=> dc_if.locked)
        else $error("fill error left data-cache status unlocked");

    a_dc_unlock_rel: assert property (@(posedge i_clk) // [RULE2]
        (dc_unl && !fill_ev) |=> !dc_if.locked)
        else $error("unlock read kept data-cache status locked");

    a_hit_follow: assert property (@(posedge i_clk) // [RULE3]
        disable iff (!i_rst_b)
        i_access_valid |=> (hit_q == $past(i_access_hit)))
        else $error("hit flag does not follow the last access");

    a_dc_second_err: assert property (@(posedge i_clk) // [RULE4]
        (fill_ev && dc_if.locked && !dc_unl) |=> dc_if.dcache_second_error)
        else $error("second fill error not flagged in data-cache status");

    a_dc_ctx_hold: assert property (@(posedge i_clk) // [RULE24]
        (dc_if.locked && !dc_unl) |=> ($stable(ra_q) && $stable(store_q)))
        else $error("locked data-cache context changed");

    a_bus_freeze: assert property (@(posedge i_clk) // [RULE8]
        (bus_if.locked && !bus_unl)
        |=> ($stable(bus_addr_q) && $stable(cmd_q) && $stable(herr_q)))
        else $error("locked bus status or address changed");

    a_fill_lock_all: assert property (@(posedge i_clk) // [RULE9]
        fill_ev |=> (bus_if.locked && fill_if.locked))
        else $error("fill error did not lock both status halves");

    a_bus_unlock: assert property (@(posedge i_clk) // [RULE10]
        (bus_unl && !bus_ev && !fill_ev)
        |=> (!bus_if.locked && !herr_q && !bus_if.dcache_second_error))
        else $error("bus address read did not unlock the low half");

    a_fill_unlock: assert property (@(posedge i_clk) // [RULE12]
        (fill_unl && !fill_ev)
        |=> (!fill_if.locked && !ecc_q && !dperr_q))
        else $error("fill address read did not unlock the high half");

    a_soft_no_seo: assert property (@(posedge i_clk) // [RULE17]
        (ack_soft && !ack_hard && !tperr && !tcperr && !bus_if.dcache_second_error
        && !bus_unl) |=> !bus_if.dcache_second_error)
        else $error("soft error set the bus second-error flag");

    a_fill_second: assert property (@(posedge i_clk) // [RULE22]
        (fill_ev && fill_if.locked && ecc_q && !fill_unl) |=> fill_if.dcache_second_error)
        else $error("second fill error not flagged");
endmodule // cbes_top
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk = 0, i_rst_b = 0, ah = 0, fe = 0, fp = 0, pm = 0, fi = 0;
    logic fint = 0, flw = 0, flf = 0, flk = 0, fst = 0, tpe = 0, tce = 0;
    logic [1:0] qw = 0;
    logic [28:0] fa = 0, ca = 0;
    logic [4:0] ra = 0;
    logic [2:0] ack = 0, req = 0;
    logic [8:0] s = 0;
    logic [63:0] rdd;
    logic dl, bl, fl;
    int failures = 0, n_compared = 0;
    always #12.5 i_clk = ~i_clk;
    cbes_top dut(.i_clk(i_clk), .i_rst_b(i_rst_b), .i_access_valid(s[0]),
        .i_access_hit(ah), .i_fill_valid(s[1]), .i_fill_ecc_err(fe),
        .i_fill_par_err(fp), .i_parity_mode(pm), .i_fill_icache(fi),
        .i_fill_bad_quadword(qw), .i_fill_addr(fa), .i_fill_ra(ra), .i_fill_int(fint),
        .i_fill_lw(flw), .i_fill_legacy_fp(flf), .i_fill_locked_op(flk),
        .i_fill_store(fst), .i_cycle_end(s[2]), .i_cycle_ack_pins(ack),
        .i_cycle_request_pins(req), .i_cycle_addr(ca), .i_tag_probe(s[3]),
        .i_tag_par_err(tpe), .i_tag_ctl_par_err(tce),
        .i_rd_dcache_status(s[4]), .i_rd_dcache_unlock(s[5]),
        .i_rd_bus_status(s[6]), .i_rd_bus_error_address(s[7]),
        .i_rd_fill_address(s[8]), .o_rd_data(rdd), .o_dcache_locked(dl),
        .o_bus_locked(bl), .o_fill_locked(fl));
    // one strobe cycle, then a quiet edge so no strobe is set twice at once
    task automatic go(input logic [8:0] m);
        @(posedge i_clk); #2; s = m;
        @(posedge i_clk); #2; s = '0;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        #2; i_rst_b = 1;
        go(9'h20); go(9'h80); go(9'h100);
        chk(64'({dl, bl, fl}), 64'h0);
        ah = 1; go(9'h1); go(9'h10);
        chk(64'(rdd[cbes_pkg::CBES_D_HIT]), 64'h1);
        ah = 0; go(9'h1); go(9'h10);
        chk(64'(rdd[cbes_pkg::CBES_D_HIT]), 64'h0);
        $display("hit test done");
        fe = 1; qw = 2'h2; fa = 29'h1abcdef; ra = 5'h13;
        fint = 1; flw = 1; flk = 1; fst = 1; go(9'h2);
        chk(64'({dl, bl, fl}), 64'h7);
        fi = 1; qw = 2'h1; fa = 29'h0123456; ra = 5'h04;
        fint = 0; flf = 1; flk = 0; fst = 0; go(9'h2);
        go(9'h40);
        chk(64'(rdd[13:8]), 64'h31);
        go(9'h10);
        chk(64'(rdd[11:1]), 64'h6e7);
        go(9'h100);
        chk(64'(rdd[33:5]), 64'h1abcdef);
        chk(64'(fl), 64'h0);
        go(9'h20);
        chk(64'(dl), 64'h0);
        chk(rdd, 64'h0);
        go(9'h80);
        chk(64'(bl), 64'h0);
        $display("fill test done");
        fe = 0; ack = cbes_pkg::CBES_ACK_HARD; req = 3'h5; ca = 29'h0a5a5a5;
        go(9'h4);
        chk(64'(bl), 64'h1);
        tpe = 1; go(9'h8); go(9'h40);
        chk(64'(rdd[7:0]), 64'hd1);
        go(9'h80);
        chk(64'(rdd[33:5]), 64'h0a5a5a5);
        tpe = 0; ack = cbes_pkg::CBES_ACK_SOFT; go(9'h4); go(9'h4); go(9'h40);
        chk(64'(rdd[7:0]), 64'h52);
        $display("bus test done");
        pm = 1; fp = 1; go(9'h2); go(9'h40);
        chk(64'(rdd[9:8]), 64'h2);
        i_rst_b = 0; repeat (2) @(posedge i_clk);
        #2; i_rst_b = 1;
        chk(64'({bl, fl}), 64'h3);
        go(9'h40);
        chk(64'(rdd[9:8]), 64'h2);
        $display("parity and reset test done");
        close_out();
    end
endmodule // tb
`default_nettype wire
